/* File: cpm_pkg.sv */
`default_nettype none
package cpm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  PTR_CONFIG      = 8'h00;
  localparam logic [7:0]  PTR_SHUNT       = 8'h01;
  localparam logic [7:0]  PTR_BUS         = 8'h02;
  localparam logic [7:0]  PTR_POWER       = 8'h03;
  localparam logic [7:0]  PTR_CURRENT     = 8'h04;
  localparam logic [7:0]  PTR_CALIBRATION = 8'h05;
  localparam logic [15:0] CONFIG_RESET    = 16'h399F;
  localparam logic [15:0] CAL_RESET       = 16'h0000;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam int          CONFIG_RST_BIT  = 15;
  localparam int          BUS_LOWEST_POS  = 3;

  // ****************************************
  // Two-wire protocol constants
  // ****************************************
  localparam logic [2:0]  ADDR_PREFIX     = 3'h4;
  localparam logic [4:0]  HS_MASTER_CODE  = 5'h01;
  localparam logic [7:0]  GENERAL_CALL    = 8'h00;
  localparam logic [7:0]  GC_RESET_BYTE   = 8'h06;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  // ****************************************
  // Arithmetic and timing
  // ****************************************
  localparam int          CURRENT_DIVISOR = 4096;
  localparam int          POWER_DIVISOR   = 5000;
  localparam int          CLK_FREQ_HZ     = 250_000_000;
  localparam int          TIMEOUT_MS      = 28;
  localparam int          TIMEOUT_CYCLES  = TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int          TIMEOUT_WIDTH   = 24;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [15:0] shunt;
    logic [12:0] busCount;
  } cpmMeas_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_MACK, ST_IGNORE
  } cpmState_t;

endpackage
`default_nettype wire

/* File: cpm_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module cpm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // ****************************************
  // Two flops; first stage read only here
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q  <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: cpm_power_calc.sv */
`timescale 1ns/1ns
`default_nettype none
module cpm_power_calc
  import cpm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        regReset,
  input  wire cpmMeas_t    meas,
  input  wire logic [15:0] calibration,
  output logic      [15:0] currentResult,
  output logic      [15:0] powerResult
);
  logic signed [32:0] curProd;
  logic signed [32:0] curQuot;
  logic        [15:0] curAbs;
  logic        [28:0] powProd;
  logic        [28:0] powQuot;
  logic               stage2_q;
  logic        [12:0] busHold_q;

  // ****************************************
  // Current then power, one stage each
  // ****************************************
  assign curProd = $signed(meas.shunt) * $signed({1'b0, calibration});
  assign curQuot = curProd / $signed(33'(CURRENT_DIVISOR));
  assign curAbs  = currentResult[15] ? 16'(-currentResult) : currentResult;
  assign powProd = 29'(curAbs) * 29'(busHold_q);
  assign powQuot = powProd / 29'(POWER_DIVISOR);

  always_ff @(posedge clk)
  begin
    if (regReset)
    begin
      currentResult <= 16'h0000;
      powerResult   <= 16'h0000;
      stage2_q      <= 1'b0;
      busHold_q     <= 13'h0000;
    end
    else
    begin
      stage2_q <= meas.valid;
      if (meas.valid)
      begin
        busHold_q     <= meas.busCount;
        // Zero calibration yields zero, no stale data kept
        currentResult <= (calibration == CAL_RESET) ? 16'h0000 : curQuot[15:0];
      end
      if (stage2_q)
        powerResult <= (calibration == CAL_RESET) ? 16'h0000 : powQuot[15:0];
    end
  end
endmodule
`default_nettype wire

/* File: cpm_i2c_port.sv */
// Function
// - Shunt result is signed, one count per 10 uV across the shunt.
// - Bus result stored left aligned, lowest bit at position three, 4 mV steps.
// - Current result equals shunt result times calibration over 4096.
// - Power result equals magnitude of current result times bus count (bus result without its three low bits) over 5000.
// - One power step weighs twenty current steps.
// - Current and power read zero until calibration is nonzero.
// - Defaults give continuous 12-bit conversions, 320 mV shunt, 32 V bus.
// - Address shifted on rising clock, last bit is direction, ack on ninth.
// - Data stable while clock high; changes there are START or STOP.
// - Stalled transaction dropped and bus released after 28 ms.
// - Address is 100, high strap code, low strap code; sixteen addresses.
// - Straps sampled again at every transaction start.
// - Slave only; fast and high speed clock rates supported.
// - Registers move as two bytes, high byte first.
// - Write: first byte loads pointer, next two write register, each acked.
// - Pointer-only write accepted; it just moves the pointer.
// - Read returns pointed register, high byte then low after master ack.
// - Pointer kept across reads until a later write.
// - High speed master code recognised, not acked, enables high speed.
// - STOP ends high speed mode and restores normal filtering.
// - Written value takes effect within 4 us.
// - General call reset equals power-on reset, like the reset bit.
`timescale 1ns/1ns
`default_nettype none
module cpm_i2c_port
  import cpm_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  input  wire logic [1:0]  addrStrapLow,
  input  wire logic [1:0]  addrStrapHigh,
  input  wire cpmMeas_t    meas,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             highSpeedMode,
  output logic      [15:0] configValue
);
  logic [5:0]               syncOut;
  logic [1:0]               strapLowS, strapHighS, byteIdx_q;
  logic [3:0]               bitCnt_q, strapLat_q;
  logic [6:0]               ownAddr;
  logic [7:0]               shift_q, hiByte_q, pointer_q, txByte;
  logic [15:0]              txWord_q, wrData_q, calibration_q, shuntResult_q, busResult_q;
  logic [15:0]              currentResult, powerResult, readWord;
  logic [TIMEOUT_WIDTH-1:0] idleCnt_q;
  cpmState_t                state_q;
  logic                     sclS, sdaS, sclD_q, sdaD_q, sclRise, sclFall, startSeen, stopSeen;
  logic                     rw_q, gcall_q, txLow_q, mackLow_q, ptrLoad_q, regWr_q, gcReset_q;
  logic                     hsSet_q, softRst_q, regReset, timeout;

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  cpm_sync #(.WIDTH(6)) u_sync (
    .clk(clk), .reset(reset),
    .asyncIn({addrStrapHigh, addrStrapLow, ~sdaIn, ~sclIn}), .syncOut(syncOut)
  );
  assign {sdaS, sclS}            = ~syncOut[1:0]; // Inverted: cleared stages read idle high
  assign {strapHighS, strapLowS} = syncOut[5:2];

  always_ff @(posedge clk)
  begin
    sclD_q <= sclS | reset;
    sdaD_q <= sdaS | reset;
  end

  assign sclRise   = sclS & ~sclD_q;
  assign sclFall   = ~sclS & sclD_q;
  assign startSeen = sclS & sclD_q & sdaD_q & ~sdaS;
  assign stopSeen  = sclS & sclD_q & ~sdaD_q & sdaS;
  assign ownAddr   = {ADDR_PREFIX, strapLat_q};
  assign txByte    = txLow_q ? txWord_q[7:0] : txWord_q[15:8];

  // ****************************************
  // Stall watchdog
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset || state_q == ST_IDLE || sclRise || sclFall)
      idleCnt_q <= '0;
    else if (!timeout)
      idleCnt_q <= idleCnt_q + 1'b1;
  end
  assign timeout = idleCnt_q == TIMEOUT_WIDTH'(TIMEOUT_LIMIT - 1);

  // ****************************************
  // Slave state machine
  // ****************************************
  always_ff @(posedge clk)
  begin
    ptrLoad_q <= 1'b0;
    regWr_q   <= 1'b0;
    gcReset_q <= 1'b0;
    hsSet_q   <= 1'b0;
    sdaOut    <= 1'b0;
    if (reset)
    begin
      state_q    <= ST_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      byteIdx_q  <= 2'h0;
      rw_q       <= 1'b0;
      gcall_q    <= 1'b0;
      strapLat_q <= 4'h0;
      hiByte_q   <= 8'h00;
      txWord_q   <= 16'h0000;
      txLow_q    <= 1'b0;
      mackLow_q  <= 1'b0;
      wrData_q   <= 16'h0000;
      sdaOe      <= 1'b0;
    end
    else if (stopSeen || timeout)
    begin
      // Either way the line is let go
      state_q <= ST_IDLE;
      sdaOe   <= 1'b0;
    end
    else if (startSeen)
    begin
      state_q    <= ST_ADDR;
      bitCnt_q   <= 4'h0;
      byteIdx_q  <= 2'h0;
      gcall_q    <= 1'b0;
      sdaOe      <= 1'b0;
      strapLat_q <= {strapHighS, strapLowS};
    end
    else
    begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: ;
        ST_ADDR:
          if (sclRise)
          begin
            shift_q  <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          else if (sclFall && bitCnt_q == BITS_PER_BYTE)
          begin
            bitCnt_q <= 4'h0;
            if (shift_q[7:1] == ownAddr)
            begin
              rw_q    <= shift_q[0];
              sdaOe   <= 1'b1;
              state_q <= ST_ADDR_ACK;
            end
            else if (shift_q == GENERAL_CALL)
            begin
              gcall_q <= 1'b1;
              rw_q    <= 1'b0;
              sdaOe   <= 1'b1;
              state_q <= ST_ADDR_ACK;
            end
            else
            begin
              hsSet_q <= shift_q[7:3] == HS_MASTER_CODE;
              state_q <= ST_IGNORE;
            end
          end
        ST_ADDR_ACK:
          if (sclFall)
          begin
            if (rw_q)
            begin
              txWord_q <= readWord;
              txLow_q  <= 1'b0;
              sdaOe    <= ~readWord[15];
              bitCnt_q <= 4'h1;
              state_q  <= ST_TX;
            end
            else
            begin
              sdaOe   <= 1'b0;
              state_q <= ST_RX;
            end
          end
        ST_RX:
          if (sclRise)
          begin
            shift_q  <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          else if (sclFall && bitCnt_q == BITS_PER_BYTE)
          begin
            bitCnt_q <= 4'h0;
            sdaOe    <= 1'b1;
            state_q  <= ST_RX_ACK;
            if (gcall_q)
              gcReset_q <= shift_q == GC_RESET_BYTE;
            else
            begin
              unique case (byteIdx_q)
                2'h0:
                begin
                  ptrLoad_q <= 1'b1;
                  wrData_q  <= {8'h00, shift_q};
                  byteIdx_q <= 2'h1;
                end
                2'h1:
                begin
                  hiByte_q  <= shift_q;
                  byteIdx_q <= 2'h2;
                end
                default:
                begin
                  regWr_q   <= 1'b1;
                  wrData_q  <= {hiByte_q, shift_q};
                  byteIdx_q <= 2'h1;
                end
              endcase
            end
          end
        ST_RX_ACK:
          if (sclFall)
          begin
            sdaOe   <= 1'b0;
            state_q <= ST_RX;
          end
        ST_TX:
          if (sclFall)
          begin
            if (bitCnt_q == BITS_PER_BYTE)
            begin
              sdaOe   <= 1'b0;
              state_q <= ST_MACK;
            end
            else
            begin
              sdaOe    <= ~txByte[3'(4'h7 - bitCnt_q)];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        ST_MACK:
          if (sclRise)
            mackLow_q <= ~sdaS;
          else if (sclFall)
          begin
            if (mackLow_q)
            begin
              txLow_q  <= ~txLow_q;
              sdaOe    <= txLow_q ? ~txWord_q[15] : ~txWord_q[7];
              bitCnt_q <= 4'h1;
              state_q  <= ST_TX;
            end
            else
              state_q <= ST_IGNORE;
          end
      endcase
    end
  end

  // ****************************************
  // High speed mode flag
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
      highSpeedMode <= 1'b0;
    else if (hsSet_q)
      highSpeedMode <= 1'b1;
    else if (stopSeen)
      highSpeedMode <= 1'b0;
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge clk)
  begin
    softRst_q <= !reset && (gcReset_q ||
                 (regWr_q && pointer_q == PTR_CONFIG && wrData_q[CONFIG_RST_BIT]));
  end
  assign regReset = reset | softRst_q;

  // Writes land the cycle after the ack starts, far inside the settle time
  always_ff @(posedge clk)
  begin
    if (regReset)
    begin
      pointer_q     <= PTR_RESET;
      configValue   <= CONFIG_RESET;
      calibration_q <= CAL_RESET;
    end
    else
    begin
      if (ptrLoad_q)
        pointer_q <= wrData_q[7:0];
      if (regWr_q && pointer_q == PTR_CONFIG && !wrData_q[CONFIG_RST_BIT])
        configValue <= wrData_q;
      if (regWr_q && pointer_q == PTR_CALIBRATION)
        calibration_q <= wrData_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (regReset)
    begin
      shuntResult_q <= 16'h0000;
      busResult_q   <= 16'h0000;
    end
    else if (meas.valid)
    begin
      shuntResult_q <= meas.shunt;
      busResult_q   <= {meas.busCount, 3'h0};
    end
  end

  cpm_power_calc u_calc (
    .clk           (clk),
    .regReset      (regReset),
    .meas          (meas),
    .calibration   (calibration_q),
    .currentResult (currentResult),
    .powerResult   (powerResult)
  );

  // Unmapped pointers read as zero
  always_comb
  begin
    unique case (pointer_q)
      PTR_CONFIG:      readWord = configValue;
      PTR_SHUNT:       readWord = shuntResult_q;
      PTR_BUS:         readWord = busResult_q;
      PTR_POWER:       readWord = powerResult;
      PTR_CURRENT:     readWord = currentResult;
      PTR_CALIBRATION: readWord = calibration_q;
      default:         readWord = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

/* File: cpm_i2c_port_props.sv */
`timescale 1ns/1ns
`default_nettype none
module cpm_i2c_port_props
  import cpm_pkg::*;
#(
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic [1:0]  addrStrapLow,
  input wire logic [1:0]  addrStrapHigh,
  input wire cpmMeas_t    meas,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        highSpeedMode,
  input wire logic [15:0] configValue
);
  // ****************************************
  // Stall counter
  // ****************************************
  logic sclPrev_q;
  int   holdCnt_q;

  always_ff @(posedge clk)
  begin
    sclPrev_q <= sclIn;
    if (reset || !sdaOe || sclIn != sclPrev_q)
      holdCnt_q <= 0;
    else
      holdCnt_q <= holdCnt_q + 1;
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_stop;
    sclIn && $rose(sdaIn);
  endsequence
  // Run twice in a row to span the ninth clock after a master code
  sequence s_quiet8;
    !sdaOe [*8];
  endsequence

  property p_rstCfg;
    $fell(reset) |-> configValue == CONFIG_RESET;
  endproperty
  property p_rstOut;
    $fell(reset) |-> !sdaOe && !highSpeedMode;
  endproperty
  property p_odOut;
    sdaOut == 1'b0;
  endproperty
  property p_ackLow;
    $rose(sdaOe) |-> !sclIn && !$past(sclIn, 3);
  endproperty
  property p_cfgWin;
    !$stable(configValue) |-> !sclIn;
  endproperty
  property p_hsNoAck;
    $rose(highSpeedMode) |-> s_quiet8 ##1 s_quiet8;
  endproperty
  property p_hsStop;
    highSpeedMode ##0 s_stop |-> ##[1:8] !highSpeedMode;
  endproperty
  // Sync lag allowance on top of the limit
  property p_timeout;
    holdCnt_q < TIMEOUT_LIMIT + 16;
  endproperty

  a_rstCfg: assert property (p_rstCfg) else $error("config not at reset value");
  a_rstOut: assert property (p_rstOut) else $error("outputs active after reset");
  a_odOut: assert property (p_odOut) else $error("data output not low");
  a_ackLow: assert property (p_ackLow) else $error("data driven while clock high");
  a_cfgWin: assert property (p_cfgWin) else $error("config moved while clock high");
  a_hsNoAck: assert property (p_hsNoAck) else $error("master code acked");
  a_hsStop: assert property (p_hsStop) else $error("high speed kept after stop");
  a_timeout: assert property (p_timeout) else $error("stalled bus not released");
endmodule

bind cpm_i2c_port cpm_i2c_port_props #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) u_props (
  .clk(clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .addrStrapLow(addrStrapLow),
  .addrStrapHigh(addrStrapHigh), .meas(meas), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .highSpeedMode(highSpeedMode), .configValue(configValue)
);
`default_nettype wire

/* File: cpm_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpm_master_model (
  input  wire logic sdaWire,
  output logic      sclLevel,
  output logic      sdaLevel
);
  // ****************************************
  // Master side of the two-wire link
  // ****************************************
  // Quarter of the 64 ns link period
  localparam int Q = 16;

  initial
  begin
    sclLevel = 1'b1;
    sdaLevel = 1'b1;
  end

  task automatic startCond();
    sdaLevel = 1'b1;
    #Q sclLevel = 1'b1;
    #Q sdaLevel = 1'b0;
    #Q sclLevel = 1'b0;
    #Q;
  endtask

  // Data only moves while the clock is low
  task automatic bitXfer(input logic b, output logic r);
    sdaLevel = b;
    #Q sclLevel = 1'b1;
    #Q r = sdaWire;
    #Q sclLevel = 1'b0;
    #Q;
  endtask

  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitXfer(b[i], r);
    bitXfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic rdByte(input logic ackOut, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitXfer(1'b1, b[i]);
    bitXfer(~ackOut, r);
  endtask

  task automatic stopCond();
    sdaLevel = 1'b0;
    #Q sclLevel = 1'b1;
    #Q sdaLevel = 1'b1;
    #Q;
  endtask
endmodule
`default_nettype wire

/* File: tb_cpm_i2c_port.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module tb_cpm_i2c_port
  import cpm_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [1:0]  strapLow = 2'b00;
  logic [1:0]  strapHigh = 2'b00;
  cpmMeas_t    meas = '0;
  logic        sdaOut;
  logic        sdaOe;
  logic        highSpeedMode;
  logic [15:0] configValue;
  logic        sclLevel;
  logic        sdaLevel;
  wire logic   sdaWire;
  logic [6:0]  devAddr;
  logic [7:0]  hi;
  logic [7:0]  lo;
  logic        ack;
  int          err_total = 0;
  int          checked = 0;

  // Pull-up wins unless someone pulls low
  assign sdaWire = sdaLevel & ~(sdaOe & ~sdaOut);
  always #2 clk = ~clk;

  // Short stall limit keeps the timeout case quick
  cpm_i2c_port #(.TIMEOUT_LIMIT(200)) dut (
    .clk(clk), .reset(reset), .sclIn(sclLevel), .sdaIn(sdaWire), .addrStrapLow(strapLow),
    .addrStrapHigh(strapHigh), .meas(meas), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .highSpeedMode(highSpeedMode), .configValue(configValue)
  );
  cpm_master_model m (.sdaWire(sdaWire), .sclLevel(sclLevel), .sdaLevel(sdaLevel));

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic xact(input logic [7:0] b, input logic expAck);
    logic a;
    m.wrByte(b, a);
    `CHK(a, expAck)
  endtask

  task automatic regWrite(input logic [7:0] ptr, input logic [15:0] v);
    m.startCond();
    xact({devAddr, 1'b0}, 1'b1);
    xact(ptr, 1'b1);
    xact(v[15:8], 1'b1);
    xact(v[7:0], 1'b1);
    m.stopCond();
  endtask

  task automatic ptrSet(input logic [7:0] ptr);
    m.startCond();
    xact({devAddr, 1'b0}, 1'b1);
    xact(ptr, 1'b1);
    m.stopCond();
  endtask

  task automatic regRead(input logic [15:0] e);
    m.startCond();
    xact({devAddr, 1'b1}, 1'b1);
    m.rdByte(1'b1, hi);
    m.rdByte(1'b0, lo);
    m.stopCond();
    `CHK({hi, lo}, e)
  endtask

  task automatic readAt(input logic [7:0] ptr, input logic [15:0] e);
    ptrSet(ptr);
    regRead(e);
  endtask

  task automatic pulse(input logic [15:0] s, input logic [12:0] b);
    @(posedge clk);
    #1 meas = {1'b1, s, b};
    @(posedge clk);
    #1 meas.valid = 1'b0;
  endtask

  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    repeat (8) @(posedge clk);
    #1 `CHK(configValue, CONFIG_RESET)
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      #1 {strapHigh, strapLow} = i[3:0];
      devAddr = {ADDR_PREFIX, i[3:0]};
      m.startCond();
      xact({devAddr, 1'b0}, 1'b1);
      m.stopCond();
    end
    m.startCond();
    xact({devAddr ^ 7'h01, 1'b0}, 1'b0);
    m.stopCond();
    pulse(16'h03E8, 13'd250);
    readAt(PTR_CURRENT, 16'h0000);
    readAt(PTR_POWER, 16'h0000);
    readAt(PTR_SHUNT, 16'h03E8);
    readAt(PTR_BUS, 16'h07D0);
    readAt(8'h07, 16'h0000);
    regWrite(PTR_CALIBRATION, 16'h0800);
    pulse(16'h03E8, 13'd250);
    readAt(PTR_CURRENT, 16'h01F4);
    readAt(PTR_POWER, 16'h0019);
    pulse(16'hFC18, 13'd250);
    regWrite(PTR_CURRENT, 16'hFFFF);
    regRead(16'hFE0C);
    regRead(16'hFE0C);
    regWrite(PTR_CONFIG, 16'h1234);
    `CHK(configValue, 16'h1234)
    regRead(16'h1234);
    ptrSet(PTR_CALIBRATION);
    regRead(16'h0800);
    regWrite(PTR_CONFIG, 16'h8000);
    `CHK(configValue, CONFIG_RESET)
    readAt(PTR_CALIBRATION, CAL_RESET);
    regWrite(PTR_CONFIG, 16'h1234);
    m.startCond();
    xact(GENERAL_CALL, 1'b1);
    xact(8'h05, 1'b1);
    m.stopCond();
    `CHK(configValue, 16'h1234)
    m.startCond();
    xact(GENERAL_CALL, 1'b1);
    xact(GC_RESET_BYTE, 1'b1);
    m.stopCond();
    `CHK(configValue, CONFIG_RESET)
    m.startCond();
    xact(8'h0B, 1'b0);
    `CHK(highSpeedMode, 1'b1)
    m.startCond();
    xact({devAddr, 1'b0}, 1'b1);
    m.stopCond();
    repeat (8) @(posedge clk);
    #1 `CHK(highSpeedMode, 1'b0)
    m.startCond();
    for (int b = 7; b >= 0; b--)
      m.bitXfer(b == 0 ? 1'b0 : devAddr[b - 1], ack);
    #40;
    `CHK(sdaOe, 1'b1)
    `CHK(sdaOut, 1'b0)
    #2000;
    `CHK(sdaOe, 1'b0)
    m.stopCond();
    readAt(PTR_CONFIG, CONFIG_RESET);
    results();
  end

  // Normal run is near 67 us; about four and a half times that means a hang
  initial
  begin
    #300000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
